// ===== verilog/otp_pkg.sv
// constants, types and field layout for the one-time-programmable memory front end
package otp_pkg;

	typedef logic [7:0]  byte_t;
	typedef logic [2:0]  fill_t;
	typedef logic [15:0] loc_t;

	// command codes on page 1
	localparam byte_t PROGRAM_DATA_OFFSET      = 8'he0;
	localparam byte_t LOCATION_LOW_OFFSET      = 8'he1;
	localparam byte_t LOCATION_HIGH_OFFSET     = 8'he2;
	localparam byte_t UNLOCK_UPPER_OFFSET      = 8'he3;
	localparam byte_t UNLOCK_MIDDLE_OFFSET     = 8'he4;
	localparam byte_t UNLOCK_LOWER_OFFSET      = 8'he5;
	localparam byte_t IDENT_MARKS_OFFSET       = 8'he6;
	localparam byte_t THIRD_IDENT_MARK_OFFSET  = 8'he7;
	localparam byte_t VOLTAGE_GAMMA_OFFSET     = 8'he8;
	localparam byte_t ACTIVITY_STATUS_OFFSET   = 8'he9;

	// page select command and its fixed bytes
	localparam byte_t PAGE_SELECT_CODE         = 8'hff;
	localparam byte_t PAGE_KEY_FIRST           = 8'h98;
	localparam byte_t PAGE_KEY_SECOND          = 8'h81;
	localparam byte_t PAGE_OF_REGS             = 8'h01;
	localparam byte_t PAGE_RESET               = 8'h01;

	localparam logic [23:0] UNLOCK_VALUE       = 24'h55aa66;
	localparam byte_t       BYTE_RESET         = 8'h00;
	localparam loc_t        LOCATION_RESET     = 16'h0000;
	localparam logic [23:0] UNLOCK_RESET       = 24'h000000;
	localparam fill_t       FILL_NONE          = 3'h0;

	// field positions inside the status bytes
	localparam int FIRST_IDENT_LSB   = 0;
	localparam int SECOND_IDENT_LSB  = 4;
	localparam int FIRST_VOLT_LSB    = 0;
	localparam int SECOND_VOLT_LSB   = 3;
	localparam int NEG_CURVE_BIT     = 6;
	localparam int POS_CURVE_BIT     = 7;
	localparam int ACTIVITY_BIT      = 7;

	// memory locations
	localparam loc_t LOC_FIRST_IDENT  = 16'h0001;
	localparam loc_t LOC_SECOND_IDENT = 16'h0002;
	localparam loc_t LOC_THIRD_IDENT  = 16'h0003;
	localparam loc_t LOC_VOLT1_HIGH   = 16'h0004;
	localparam loc_t LOC_VOLT1_LOW    = 16'h0005;
	localparam loc_t LOC_VOLT2_HIGH   = 16'h0006;
	localparam loc_t LOC_VOLT2_LOW    = 16'h0007;
	localparam loc_t LOC_FIRST_REG    = 16'h0008;
	localparam loc_t LOC_SECOND_REG   = 16'h0009;
	localparam loc_t LOC_POS_FIRST    = 16'h0068;
	localparam loc_t LOC_POS_LAST     = 16'h007b;
	localparam loc_t LOC_NEG_FIRST    = 16'h007c;
	localparam loc_t LOC_NEG_LAST     = 16'h008f;
	localparam int   NV_DEPTH         = 144;

	// programming time
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          PROGRAM_TIME_NS = 10000;
	localparam int          PROGRAM_CYCLES  = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] BURN_LAST_COUNT = 16'(PROGRAM_CYCLES - 1);

	typedef enum logic [3:0] {
		item_none, item_id1, item_id2, item_id3, item_first_common_voltage, item_second_common_voltage, item_reg, item_gamp, item_gamn
	} item_e;

	typedef enum logic {st_idle, st_burn} state_e;

endpackage

// ===== verilog/otp_cell_array.sv
// storage array of the one-time-programmable memory with a registered read port
`timescale 1ns/1ps
module otp_cell_array
	import otp_pkg::*;
(
	input  wire logic           sys_clk,
	input  wire logic           sys_rst,
	input  wire logic           wr_en,
	input  wire logic [7:0]     wr_loc,
	input  wire otp_pkg::byte_t wr_byte,
	input  wire logic [7:0]     rd_loc,
	output otp_pkg::byte_t      rd_byte
);

	import otp_pkg::*;

	byte_t cells [NV_DEPTH];

	wire rd_inside = (int'(rd_loc) < NV_DEPTH);

	// contents are non-volatile, so the cells themselves take no reset
	always_ff @(posedge sys_clk)
	begin
		if (wr_en && (int'(wr_loc) < NV_DEPTH))
			cells[wr_loc] <= wr_byte;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rd_byte <= BYTE_RESET;
		else
			rd_byte <= rd_inside ? cells[rd_loc] : BYTE_RESET;
	end

endmodule

// ===== verilog/otp_program_control.sv
// command-register front end that programs the one-time-programmable memory
`timescale 1ns/1ps
//
// Overview of operation
// - programming starts only when the 24-bit unlock word equals 55aa66
// - wrong unlock word at an attempt abandons it, memory untouched
// - a completed operation stores the program byte at the selected location
// - location is 16 bits, low byte at e1, high byte at e2, combined
// - locations 1-3 identity, 4-7 two 9-bit voltages high first, 8-9 regulators
// - 68-7b positive curve points, 7c-8f negative curve points
// - unlock word spans e3..e5, most significant byte first
// - programming an identity item, a voltage low byte or a curve's last point advances its read-only count mark
// - three-bit marks use fill code 000, 001, 011, 111
// - identity and voltage items allow at most three programmings
// - curve marks are one bit, set once the curve's last point is programmed
// - marks packed into e6, e7 and e8 as laid out
// - e9 bit 7 shows busy while programming, other bits read zero
// - data, location and unlock registers reset to zero on every reset
// - registers stay reachable in every power mode
module otp_program_control
	import otp_pkg::*;
(
	input  wire logic           sys_clk,
	input  wire logic           sys_rst,
	input  wire logic           sw_reset,
	input  wire logic           cmd_valid,
	input  wire otp_pkg::byte_t cmd_code,
	input  wire logic [1:0]     cmd_param_index,
	input  wire otp_pkg::byte_t cmd_param,
	input  wire logic           rd_req,
	input  wire otp_pkg::byte_t rd_code,
	input  wire logic [7:0]     nv_read_location,
	output otp_pkg::byte_t      rd_data,
	output logic                rd_valid,
	output logic                busy,
	output logic                program_done,
	output logic                program_refused,
	output otp_pkg::byte_t      nv_read_byte
);

	import otp_pkg::*;

	localparam int BURN_SPAN = PROGRAM_CYCLES;
	localparam int BURN_LAST = PROGRAM_CYCLES - 1;

	//////////////////////////////////////////////////////////////////////////////
	// location decode

	function automatic item_e item_of(input loc_t loc);
		if (loc == LOC_FIRST_IDENT)
			return item_id1;
		if (loc == LOC_SECOND_IDENT)
			return item_id2;
		if (loc == LOC_THIRD_IDENT)
			return item_id3;
		if (loc == LOC_VOLT1_HIGH || loc == LOC_VOLT1_LOW)
			return item_first_common_voltage;
		if (loc == LOC_VOLT2_HIGH || loc == LOC_VOLT2_LOW)
			return item_second_common_voltage;
		if (loc == LOC_FIRST_REG || loc == LOC_SECOND_REG)
			return item_reg;
		if (loc >= LOC_POS_FIRST && loc <= LOC_POS_LAST)
			return item_gamp;
		if (loc >= LOC_NEG_FIRST && loc <= LOC_NEG_LAST)
			return item_gamn;
		return item_none;
	endfunction

	// a 9-bit voltage counts once its low byte lands; a curve once its last point lands
	function automatic logic loc_advances(input loc_t loc);
		return !(loc == LOC_VOLT1_HIGH || loc == LOC_VOLT2_HIGH ||
			(loc >= LOC_POS_FIRST && loc < LOC_POS_LAST) ||
			(loc >= LOC_NEG_FIRST && loc < LOC_NEG_LAST));
	endfunction

	function automatic fill_t fill_step(input fill_t mark);
		return {mark[1:0], 1'b1};
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// state

	byte_t       program_byte;
	loc_t        program_location;
	logic [23:0] unlock_word;
	fill_t       first_ident_count;
	fill_t       second_ident_count;
	fill_t       third_ident_count;
	fill_t       first_voltage_count;
	fill_t       second_voltage_count;
	logic        positive_curve_count;
	logic        negative_curve_count;
	state_e      state;
	logic [15:0] burn_timer;
	byte_t       burn_byte;
	logic [7:0]  burn_loc;
	item_e       burn_item;
	logic        burn_advance;
	byte_t       page;
	logic [1:0]  page_key_ok;

	//////////////////////////////////////////////////////////////////////////////
	// command decode

	wire page_cmd    = cmd_valid && cmd_code == PAGE_SELECT_CODE;
	wire reg_write   = cmd_valid && page == PAGE_OF_REGS && cmd_param_index == 2'd0;
	// settings are frozen while burning so the operation in flight cannot be corrupted
	wire regs_open   = reg_write && state == st_idle;
	wire wr_data     = regs_open && cmd_code == PROGRAM_DATA_OFFSET;
	wire wr_loc_low  = regs_open && cmd_code == LOCATION_LOW_OFFSET;
	wire wr_loc_high = regs_open && cmd_code == LOCATION_HIGH_OFFSET;
	wire wr_key_up   = regs_open && cmd_code == UNLOCK_UPPER_OFFSET;
	wire wr_key_mid  = regs_open && cmd_code == UNLOCK_MIDDLE_OFFSET;
	wire wr_key_low  = regs_open && cmd_code == UNLOCK_LOWER_OFFSET;

	wire   key_ok       = unlock_word == UNLOCK_VALUE;
	item_e attempt_item;
	assign attempt_item = item_of(program_location);
	wire   item_full    = (attempt_item == item_id1  && first_ident_count[2])   ||
	                      (attempt_item == item_id2  && second_ident_count[2])  ||
	                      (attempt_item == item_id3  && third_ident_count[2])   ||
	                      (attempt_item == item_first_common_voltage && first_voltage_count[2]) ||
	                      (attempt_item == item_second_common_voltage && second_voltage_count[2])||
	                      (attempt_item == item_gamp && positive_curve_count)   ||
	                      (attempt_item == item_gamn && negative_curve_count);
	wire   start_ok     = wr_data && key_ok && attempt_item != item_none && !item_full;
	wire   refuse       = wr_data && !start_ok;
	wire   timer_done   = burn_timer == BURN_LAST_COUNT;
	wire   nv_wr_en     = state == st_burn && timer_done;

	//////////////////////////////////////////////////////////////////////////////
	// page select and host registers

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			page        <= PAGE_RESET;
			page_key_ok <= 2'b00;
		end
		else if (sw_reset)
		begin
			page        <= PAGE_RESET;
			page_key_ok <= 2'b00;
		end
		else if (page_cmd)
		begin
			page_key_ok[0] <= cmd_param_index == 2'd0 && cmd_param == PAGE_KEY_FIRST;
			page_key_ok[1] <= cmd_param_index == 2'd1 && cmd_param == PAGE_KEY_SECOND && page_key_ok[0];
			if (cmd_param_index == 2'd2 && page_key_ok[1])
				page <= cmd_param;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			program_byte     <= BYTE_RESET;
			program_location <= LOCATION_RESET;
			unlock_word      <= UNLOCK_RESET;
		end
		else if (sw_reset)
		begin
			program_byte     <= BYTE_RESET;
			program_location <= LOCATION_RESET;
			unlock_word      <= UNLOCK_RESET;
		end
		else
		begin
			if (wr_data)
				program_byte <= cmd_param;
			if (wr_loc_low)
				program_location[7:0] <= cmd_param;
			if (wr_loc_high)
				program_location[15:8] <= cmd_param;
			if (wr_key_up)
				unlock_word[23:16] <= cmd_param;
			if (wr_key_mid)
				unlock_word[15:8] <= cmd_param;
			if (wr_key_low)
				unlock_word[7:0] <= cmd_param;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// programming sequencer

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state           <= st_idle;
			busy            <= 1'b0;
			burn_timer      <= 16'h0000;
			burn_byte       <= BYTE_RESET;
			burn_loc        <= 8'h00;
			burn_item       <= item_none;
			burn_advance    <= 1'b0;
			program_done    <= 1'b0;
			program_refused <= 1'b0;
		end
		else
		begin
			program_done    <= nv_wr_en;
			program_refused <= refuse;
			unique case (state)
				st_idle:
				begin
					burn_timer <= 16'h0000;
					if (start_ok)
					begin
						state        <= st_burn;
						busy         <= 1'b1;
						burn_byte    <= cmd_param;
						burn_loc     <= program_location[7:0];
						burn_item    <= attempt_item;
						burn_advance <= loc_advances(program_location);
					end
				end
				st_burn:
				begin
					burn_timer <= burn_timer + 16'h0001;
					if (timer_done)
					begin
						state <= st_idle;
						busy  <= 1'b0;
					end
				end
			endcase
		end
	end

	// marks live with the memory contents: only a power-on reset clears them
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			first_ident_count    <= FILL_NONE;
			second_ident_count   <= FILL_NONE;
			third_ident_count    <= FILL_NONE;
			first_voltage_count  <= FILL_NONE;
			second_voltage_count <= FILL_NONE;
			positive_curve_count <= 1'b0;
			negative_curve_count <= 1'b0;
		end
		else if (nv_wr_en && burn_advance)
		begin
			if (burn_item == item_id1)
				first_ident_count <= fill_step(first_ident_count);
			if (burn_item == item_id2)
				second_ident_count <= fill_step(second_ident_count);
			if (burn_item == item_id3)
				third_ident_count <= fill_step(third_ident_count);
			if (burn_item == item_first_common_voltage)
				first_voltage_count <= fill_step(first_voltage_count);
			if (burn_item == item_second_common_voltage)
				second_voltage_count <= fill_step(second_voltage_count);
			if (burn_item == item_gamp)
				positive_curve_count <= 1'b1;
			if (burn_item == item_gamn)
				negative_curve_count <= 1'b1;
		end
	end

	otp_cell_array cells
	(
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.wr_en   (nv_wr_en),
		.wr_loc  (burn_loc),
		.wr_byte (burn_byte),
		.rd_loc  (nv_read_location),
		.rd_byte (nv_read_byte)
	);

	//////////////////////////////////////////////////////////////////////////////
	// read-back; no power-mode gating, reads work in every mode

	byte_t ident_view;
	byte_t third_view;
	byte_t voltage_view;
	byte_t activity_view;
	byte_t rd_value;

	assign ident_view    = {1'b0, second_ident_count, 1'b0, first_ident_count};
	assign third_view    = {5'h00, third_ident_count};
	assign voltage_view  = {positive_curve_count, negative_curve_count,
	                        second_voltage_count, first_voltage_count};
	assign activity_view = {busy, 7'h00};
	assign rd_value      = (page != PAGE_OF_REGS)                ? BYTE_RESET :
	                       (rd_code == PROGRAM_DATA_OFFSET)      ? program_byte :
	                       (rd_code == LOCATION_LOW_OFFSET)      ? program_location[7:0] :
	                       (rd_code == LOCATION_HIGH_OFFSET)     ? program_location[15:8] :
	                       (rd_code == UNLOCK_UPPER_OFFSET)      ? unlock_word[23:16] :
	                       (rd_code == UNLOCK_MIDDLE_OFFSET)     ? unlock_word[15:8] :
	                       (rd_code == UNLOCK_LOWER_OFFSET)      ? unlock_word[7:0] :
	                       (rd_code == IDENT_MARKS_OFFSET)       ? ident_view :
	                       (rd_code == THIRD_IDENT_MARK_OFFSET)  ? third_view :
	                       (rd_code == VOLTAGE_GAMMA_OFFSET)     ? voltage_view :
	                       (rd_code == ACTIVITY_STATUS_OFFSET)   ? activity_view : BYTE_RESET;

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_data  <= BYTE_RESET;
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_valid <= rd_req;
			rd_data  <= rd_req ? rd_value : BYTE_RESET;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// assertions

	property p_start_needs_key;
		@(posedge sys_clk) disable iff (sys_rst)
		$rose(busy) |-> $past(unlock_word) == UNLOCK_VALUE;
	endproperty
	a_start_needs_key: assert property (p_start_needs_key) else $error("programming began without unlock");

	property p_bad_key_abandons;
		@(posedge sys_clk) disable iff (sys_rst)
		(wr_data && unlock_word != UNLOCK_VALUE) |=> (!busy && program_refused) ##1 !busy;
	endproperty
	a_bad_key_abandons: assert property (p_bad_key_abandons) else $error("wrong key did not abandon");

	property p_byte_stored;
		@(posedge sys_clk) disable iff (sys_rst)
		$rose(busy) |-> ##BURN_LAST (nv_wr_en && burn_byte == $past(cmd_param, BURN_SPAN));
	endproperty
	a_byte_stored: assert property (p_byte_stored) else $error("stored byte is not the written byte");

	property p_location_high;
		@(posedge sys_clk) disable iff (sys_rst)
		(wr_loc_high && !sw_reset) |=> program_location[15:8] == $past(cmd_param) && $stable(program_location[7:0]);
	endproperty
	a_location_high: assert property (p_location_high) else $error("location high byte wrong");

	property p_key_upper;
		@(posedge sys_clk) disable iff (sys_rst)
		(wr_key_up && !sw_reset) |=> unlock_word[23:16] == $past(cmd_param) && $stable(unlock_word[15:0]);
	endproperty
	a_key_upper: assert property (p_key_upper) else $error("unlock upper byte wrong");

	property p_fill_step;
		@(posedge sys_clk) disable iff (sys_rst)
		(nv_wr_en && burn_advance && burn_item == item_id1) |=>
			first_ident_count == {$past(first_ident_count[1:0]), 1'b1};
	endproperty
	a_fill_step: assert property (p_fill_step) else $error("identity mark did not advance");

	property p_full_refused;
		@(posedge sys_clk) disable iff (sys_rst)
		(wr_data && program_location == LOC_FIRST_IDENT && first_ident_count[2]) |=> !busy ##1 !busy;
	endproperty
	a_full_refused: assert property (p_full_refused) else $error("full item was programmed again");

	property p_curve_mark;
		@(posedge sys_clk) disable iff (sys_rst)
		$rose(positive_curve_count) |-> $past(nv_wr_en) && $past(burn_loc) == LOC_POS_LAST[7:0];
	endproperty
	a_curve_mark: assert property (p_curve_mark) else $error("curve mark set without last point");

	property p_activity_read;
		@(posedge sys_clk) disable iff (sys_rst)
		(rd_req && rd_code == ACTIVITY_STATUS_OFFSET && page == PAGE_OF_REGS) |=>
			rd_valid && rd_data == {$past(busy), 7'h00};
	endproperty
	a_activity_read: assert property (p_activity_read) else $error("activity status read wrong");

	property p_busy_span;
		@(posedge sys_clk) disable iff (sys_rst)
		$rose(busy) |-> ##BURN_SPAN $fell(busy);
	endproperty
	a_busy_span: assert property (p_busy_span) else $error("busy span wrong");

	property p_soft_reset;
		@(posedge sys_clk) disable iff (sys_rst)
		sw_reset |=> program_byte == BYTE_RESET && program_location == LOCATION_RESET && unlock_word == UNLOCK_RESET;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset left registers set");

	c_program_done: cover property (@(posedge sys_clk) disable iff (sys_rst) program_done);
	c_refused: cover property (@(posedge sys_clk) disable iff (sys_rst) program_refused);
	c_ident_full: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(first_ident_count[2]));
	c_curve_set: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(negative_curve_count));

endmodule

// ===== test/host_model.sv
// host-side model: issues page-one commands, register reads and waits for idle
`timescale 1ns/1ps
module host_model
	import otp_pkg::*;
(
	input  wire logic           sys_clk,
	input  wire logic           busy,
	input  wire logic           rd_valid,
	input  wire otp_pkg::byte_t rd_data,
	output logic                cmd_valid,
	output otp_pkg::byte_t      cmd_code,
	output logic [1:0]          cmd_param_index,
	output otp_pkg::byte_t      cmd_param,
	output logic                rd_req,
	output otp_pkg::byte_t      rd_code
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_param_index = 2'h3;
		cmd_param = 8'h00;
		rd_req = 1'b0;
		rd_code = 8'h00;
	end

	////////////////////////////////////////////////////////////////
	// released code and value fields are inverted so a stale value never looks live
	task automatic wr(input byte_t code, input byte_t val, input logic [1:0] idx = 2'h0);
		@(posedge sys_clk);
		#1;
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_param_index = idx;
		cmd_param = val;
		@(posedge sys_clk);
		#1;
		cmd_valid = 1'b0;
		cmd_code = ~code;
		cmd_param = ~val;
	endtask

	task automatic rd(input byte_t code, output byte_t val, output logic ok);
		@(posedge sys_clk);
		#1;
		rd_req = 1'b1;
		rd_code = code;
		@(posedge sys_clk);
		#1;
		rd_req = 1'b0;
		rd_code = ~code;
		val = rd_data;
		ok = rd_valid;
	endtask

	task automatic page(input byte_t p);
		wr(PAGE_SELECT_CODE, PAGE_KEY_FIRST, 2'h0);
		wr(PAGE_SELECT_CODE, PAGE_KEY_SECOND, 2'h1);
		wr(PAGE_SELECT_CODE, p, 2'h2);
	endtask

	// bounded poll; n is the number of edges seen with busy high
	task automatic wait_idle(output int n);
		n = 0;
		while (busy === 1'b1 && n < 400)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask
endmodule

// ===== test/tb_top.sv
// self-checking bench for the programming front end
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
	import otp_pkg::*;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        sw_reset = 1'b0;
	logic [7:0]  nv_read_location = 8'h00;
	logic        cmd_valid, rd_req, rd_valid, busy, program_done, program_refused;
	logic [1:0]  cmd_param_index;
	byte_t       cmd_code, cmd_param, rd_code, rd_data, nv_read_byte, got;
	logic        ok;
	int          failures = 0;
	int          total_checks = 0;
	int          n;
	loc_t        locs [9] = '{16'h2, 16'h3, 16'h4, 16'h5, 16'h7, 16'h8, 16'h68, 16'h7b, 16'h8f};
	byte_t       regs [9] = '{8'he6, 8'he7, 8'he8, 8'he8, 8'he8, 8'he8, 8'he8, 8'he8, 8'he8};
	byte_t       exps [9] = '{8'h17, 8'h01, 8'h00, 8'h01, 8'h09, 8'h09, 8'h09, 8'h89, 8'hc9};
	loc_t        bad [4] = '{16'h0010, 16'h0101, 16'h007b, 16'h0001};

	always #50 sys_clk = ~sys_clk;

	otp_program_control dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sw_reset(sw_reset),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_param_index(cmd_param_index),
		.cmd_param(cmd_param), .rd_req(rd_req), .rd_code(rd_code), .nv_read_location(nv_read_location),
		.rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .program_done(program_done),
		.program_refused(program_refused), .nv_read_byte(nv_read_byte));

	host_model h (.sys_clk(sys_clk), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_param_index(cmd_param_index),
		.cmd_param(cmd_param), .rd_req(rd_req), .rd_code(rd_code));

	////////////////////////////////////////////////////////////////
	task automatic rdchk(input byte_t code, input byte_t e);
		h.rd(code, got, ok);
		`CHK(ok, 1'b1)
		`CHK(got, e)
	endtask

	task automatic peek(input byte_t loc, input byte_t e);
		@(posedge sys_clk);
		#1;
		nv_read_location = loc;
		repeat (2) @(posedge sys_clk);
		#1;
		`CHK(nv_read_byte, e)
	endtask

	// the data write is the attempt; outcome checked from the cycle after it
	task automatic prog(input loc_t loc, input byte_t d, input logic good);
		h.wr(LOCATION_LOW_OFFSET, loc[7:0]);
		h.wr(LOCATION_HIGH_OFFSET, loc[15:8]);
		h.wr(PROGRAM_DATA_OFFSET, d);
		`CHK(busy, good)
		`CHK(program_refused, ~good)
		h.wait_idle(n);
		if (good)
		begin
			`CHK(n, PROGRAM_CYCLES)
			`CHK(program_done, 1'b1)
		end
	endtask

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask

	task automatic test_done;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#2000000;
		failures++;
		test_done;
	end

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		for (int i = 0; i < 10; i++)
			rdchk(8'he0 + 8'(i), 8'h00);
		tdone("reset");
		for (int i = 0; i < 6; i++)
			h.wr(8'he0 + 8'(i), 8'h11 * 8'(i + 1));
		for (int i = 0; i < 6; i++)
			rdchk(8'he0 + 8'(i), 8'h11 * 8'(i + 1));
		@(posedge sys_clk);
		#1;
		sw_reset = 1'b1;
		@(posedge sys_clk);
		#1;
		sw_reset = 1'b0;
		for (int i = 0; i < 6; i++)
			rdchk(8'he0 + 8'(i), 8'h00);
		tdone("registers");
		prog(16'h1, 8'h3c, 1'b0);
		h.wr(UNLOCK_UPPER_OFFSET, 8'h66);
		h.wr(UNLOCK_MIDDLE_OFFSET, 8'haa);
		h.wr(UNLOCK_LOWER_OFFSET, 8'h55);
		prog(16'h1, 8'h3c, 1'b0);
		rdchk(IDENT_MARKS_OFFSET, 8'h00);
		h.wr(UNLOCK_UPPER_OFFSET, 8'h55);
		h.wr(UNLOCK_LOWER_OFFSET, 8'h66);
		tdone("key");
		h.wr(LOCATION_LOW_OFFSET, 8'h01);
		h.wr(PROGRAM_DATA_OFFSET, 8'ha1);
		h.wr(LOCATION_LOW_OFFSET, 8'h33);
		rdchk(ACTIVITY_STATUS_OFFSET, 8'h80);
		h.wait_idle(n);
		rdchk(LOCATION_LOW_OFFSET, 8'h01);
		rdchk(ACTIVITY_STATUS_OFFSET, 8'h00);
		rdchk(IDENT_MARKS_OFFSET, 8'h01);
		prog(16'h1, 8'ha2, 1'b1);
		rdchk(IDENT_MARKS_OFFSET, 8'h03);
		prog(16'h1, 8'ha3, 1'b1);
		rdchk(IDENT_MARKS_OFFSET, 8'h07);
		peek(8'h01, 8'ha3);
		tdone("first identity");
		for (int i = 0; i < 9; i++)
		begin
			prog(locs[i], locs[i][7:0] ^ 8'h5a, 1'b1);
			rdchk(regs[i], exps[i]);
			peek(locs[i][7:0], locs[i][7:0] ^ 8'h5a);
		end
		tdone("items");
		for (int i = 0; i < 4; i++)
			prog(bad[i], 8'hee, 1'b0);
		rdchk(IDENT_MARKS_OFFSET, 8'h17);
		rdchk(VOLTAGE_GAMMA_OFFSET, 8'hc9);
		peek(8'h01, 8'ha3);
		tdone("refusals");
		h.page(8'h02);
		rdchk(IDENT_MARKS_OFFSET, 8'h00);
		h.page(PAGE_OF_REGS);
		rdchk(THIRD_IDENT_MARK_OFFSET, 8'h01);
		tdone("page");
		test_done;
	end
endmodule
